// ==== src/acs_map.vh ====
// Constants for the conversion sequencer: timing, formats, serial frame.
// Assumes a 10 MHz system clock; included by the sequencer files.
`ifndef ACS_MAP_VH
`define ACS_MAP_VH
`define ACS_SYS_CLK_MHZ       10
`define ACS_CONV_HS_NS        5000
`define ACS_CONV_SLEEP_NS     10000
`define ACS_WAKE_NS           5000
`define ACS_ACQ_NS            350
`define ACS_QUIET_NS          250
`define ACS_SYNC_CYC          3
`define ACS_CONV_CLK_DIV      4'h4
`define ACS_CODE_W            14
`define ACS_FRAME_BITS        5'h10
`define ACS_LEAD_ZEROS        2
`define ACS_HOLD_CYC          2'h1
`define ACS_SIGN_BIT          13
`endif

// ==== src/acs_sequencer.v ====
// Conversion sequencer: start edge, busy, modes, result coding, readout.
// Assumes start and serial clock are asynchronous pins; code from SAR core.
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_sequencer
#(
  parameter BIPOLAR = 1
)
(
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // Host pins
  input  wire        conversion_start_n_i,
  input  wire        serial_clk_i,
  // Converter core
  input  wire [13:0] sar_code_i,
  // Status and data
  output reg         busy_o,
  output reg         track_hold_o,
  output reg         sleep_o,
  output wire        serial_result_out_o,
  output wire        serial_result_oe_o
);
  // Cycle counts: conversion clock ticks per phase, rounded down.
  // The pin synchroniser's delay comes out of the conversion budget, so busy
  // falls inside the limit counted from the pin, whatever the tick phase.
  localparam [3:0]   CDIV      = `ACS_CONV_CLK_DIV;
  localparam integer CONV_CYC  = `ACS_CONV_HS_NS * `ACS_SYS_CLK_MHZ / 1000;
  localparam integer WAKE_CYC  = `ACS_WAKE_NS * `ACS_SYS_CLK_MHZ / 1000;
  localparam integer HS_TK_I   = (CONV_CYC - `ACS_SYNC_CYC) / `ACS_CONV_CLK_DIV;
  localparam integer WAKE_TK_I = WAKE_CYC / `ACS_CONV_CLK_DIV;
  localparam [15:0]  HS_TK     = HS_TK_I[15:0];
  localparam [15:0]  WAKE_TK   = WAKE_TK_I[15:0];
  // Idle pin levels: start high, serial clock low
  localparam [1:0]   PIN_IDLE  = 2'h1;

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_CONV  = 2'h1;
  localparam [1:0] ST_SLEEP = 2'h2;
  localparam [1:0] ST_WAKE  = 2'h3;

  reg [1:0]  state;
  reg [15:0] ticks;
  reg [3:0]  cdiv;
  wire [1:0] pin_raw;
  wire [1:0] pin_now;
  wire [1:0] pin_old;
  genvar     p;
  reg [13:0] result;
  reg        frame_reset;
  reg        pending;
  wire       conv_tick;
  wire       start_fall;
  wire       start_rise;
  wire       sclk_fall;
  wire [13:0] coded;

  // Pins pass two flops; edges are taken between stages two and three
  assign pin_raw = {serial_clk_i, conversion_start_n_i};
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_sync
      reg [2:0] stage;
      always @(posedge clk_sys_i)
      begin
        // Preloaded with the idle level so reset leaves no false edge
        if (rst_i)
          stage <= {3{PIN_IDLE[p]}};
        else
          stage <= {stage[1:0], pin_raw[p]};
      end
      assign pin_now[p] = stage[1];
      assign pin_old[p] = stage[2];
    end
  endgenerate
  assign start_fall = pin_old[0] & ~pin_now[0];
  assign start_rise = ~pin_old[0] & pin_now[0];
  assign sclk_fall  = pin_old[1] & ~pin_now[1];

  // Free-running internal conversion clock; no host clock needed
  always @(posedge clk_sys_i)
  begin
    if (rst_i)
      cdiv <= 4'h0;
    else if (cdiv == CDIV - 4'h1)
      cdiv <= 4'h0;
    else
      cdiv <= cdiv + 4'h1;
  end
  assign conv_tick = (cdiv == CDIV - 4'h1);

  // Core code is offset binary; bipolar flips the sign so ground reads 0
  generate
    if (BIPOLAR != 0)
    begin : g_bipolar
      assign coded = {~sar_code_i[`ACS_SIGN_BIT], sar_code_i[12:0]};
    end
    else
    begin : g_unipolar
      // Straight binary passes the core code through untouched
      assign coded = sar_code_i;
    end
  endgenerate

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      state        <= ST_IDLE;
      ticks        <= 16'h0000;
      busy_o       <= 1'b0;
      track_hold_o <= 1'b0;
      sleep_o      <= 1'b0;
      result       <= 14'h0000;
      frame_reset  <= 1'b0;
      pending      <= 1'b0;
    end
    else
    begin
      frame_reset <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (start_fall)
          begin
            state        <= ST_CONV;
            track_hold_o <= 1'b1;
            busy_o       <= 1'b1;
            ticks        <= 16'h0000;
            frame_reset  <= 1'b1;
          end
        end
        ST_CONV:
        begin
          if (conv_tick)
          begin
            if (ticks == HS_TK - 16'h0001)
            begin
              // Whole word loads at once, never mixed
              result       <= coded;
              busy_o       <= 1'b0;
              track_hold_o <= 1'b0;
              frame_reset  <= 1'b1;
              if (~pin_old[0])
              begin
                state   <= ST_SLEEP;
                sleep_o <= 1'b1;
              end
              else
                state <= ST_IDLE;
            end
            else
              ticks <= ticks + 16'h0001;
          end
        end
        ST_SLEEP:
        begin
          if (start_rise)
          begin
            state   <= ST_WAKE;
            ticks   <= 16'h0000;
            pending <= 1'b0;
          end
        end
        ST_WAKE:
        begin
          // A short pulse falls here; its hold starts at wake end
          if (start_fall)
            pending <= 1'b1;
          if (conv_tick)
          begin
            if (ticks == WAKE_TK - 16'h0001)
            begin
              sleep_o <= 1'b0;
              if (pending | start_fall | ~pin_old[0])
              begin
                state        <= ST_CONV;
                track_hold_o <= 1'b1;
                busy_o       <= 1'b1;
                frame_reset  <= 1'b1;
                ticks        <= 16'h0000;
              end
              else
                state <= ST_IDLE;
            end
            else
              ticks <= ticks + 16'h0001;
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  acs_serial_out u_serial
  (
    .clk_sys_i           (clk_sys_i),
    .rst_i               (rst_i),
    .frame_reset_i       (frame_reset),
    .sclk_fall_i         (sclk_fall),
    .result_i            (result),
    .serial_result_out_o (serial_result_out_o),
    .serial_result_oe_o  (serial_result_oe_o)
  );
endmodule

// ==== src/acs_serial_out.v ====
// Serial result shifter: 16 bits out on falling serial clock edges.
// Assumes serial clock already synchronised to clk_sys_i by the caller.
`timescale 1ns/100ps
`include "acs_map.vh"
module acs_serial_out
(
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // Control
  input  wire        frame_reset_i,
  input  wire        sclk_fall_i,
  input  wire [13:0] result_i,
  // Serial pin
  output reg         serial_result_out_o,
  output reg         serial_result_oe_o
);
  reg [15:0] shift;
  reg [4:0]  count;
  reg [1:0]  hold;

  always @(posedge clk_sys_i)
  begin
    if (rst_i)
    begin
      shift               <= 16'h0000;
      count               <= 5'h00;
      hold                <= 2'h0;
      serial_result_out_o <= 1'b0;
      serial_result_oe_o  <= 1'b0;
    end
    else if (frame_reset_i)
    begin
      // Reloaded each start so every frame begins from a known state
      shift               <= {2'h0, result_i};
      count               <= 5'h00;
      hold                <= 2'h0;
      serial_result_out_o <= 1'b0;
      serial_result_oe_o  <= 1'b1;
    end
    else
    begin
      if (sclk_fall_i)
      begin
        // First bit stands from the frame start and each fall brings the next;
        // the sixteenth fall leaves the last bit standing until release
        if (count != `ACS_FRAME_BITS - 5'h01)
          serial_result_out_o <= shift[14];
        shift               <= {shift[14:0], 1'b0};
        if (count == `ACS_FRAME_BITS - 5'h01)
          hold <= `ACS_HOLD_CYC;
        count <= count + 5'h01;
      end
      if (hold != 2'h0)
      begin
        hold <= hold - 2'h1;
        if (hold == 2'h1)
          serial_result_oe_o <= 1'b0;
      end
    end
  end
endmodule

// ==== test/acs_host.sv ====
// Host model: start pin and 16-clock reads of two data lines.
// Assumes 10 MHz clock; serial clock idles low between frames.
`timescale 1ns/100ps
module acs_host
(
  input  wire       clk_sys_i,
  input  wire [1:0] sdat_i,
  output reg        start_n_o,
  output reg        sclk_o
);
  reg [15:0] w [0:1];
  initial
  begin
    start_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  task start(input v);
    @(posedge clk_sys_i) start_n_o <= v;
  endtask
  // 800 ns period; sampled just before each fall, as the pin allows
  task read;
    integer i;
    for (i = 0; i < 16; i = i + 1)
    begin
      @(posedge clk_sys_i) sclk_o <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      w[0] = {w[0][14:0], sdat_i[0]};
      w[1] = {w[1][14:0], sdat_i[1]};
      @(posedge clk_sys_i) sclk_o <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
endmodule

// ==== test/acs_sequencer_sva.sv ====
// Pin checker for the sequencer.
// Assumes the start pin is steady for 4 cycles around conversion end.
`timescale 1ns/100ps
module acs_sequencer_sva
(
  // Pins
  input wire clk_sys_i,
  input wire rst_i,
  input wire conversion_start_n_i,
  input wire busy_o,
  input wire track_hold_o,
  input wire sleep_o,
  input wire serial_result_oe_o
);
  reg [6:0] n;
  always @(posedge clk_sys_i)
    n <= busy_o ? n + 7'h01 : 7'h00;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_busy_rise: assert property
    ($fell(conversion_start_n_i) && !busy_o && !sleep_o |-> ##[3:5] busy_o) else $error("b");
  chk_hold_busy: assert property (busy_o |-> track_hold_o) else $error("h");
  chk_track_end: assert property ($fell(busy_o) |-> ##[0:1] !track_hold_o) else $error("t");
  chk_conv_max: assert property (busy_o |-> n < 7'h2F) else $error("l");
  chk_conv_min: assert property ($fell(busy_o) |-> n > 7'h28) else $error("s");
  chk_wake_time: assert property
    ($rose(conversion_start_n_i) && sleep_o ##[1:20] $fell(conversion_start_n_i)
     |-> ##[72:99] $fell(busy_o)) else $error("w");
  chk_sleep_mode: assert property
    ($fell(busy_o) && conversion_start_n_i == $past(conversion_start_n_i, 4)
     |-> sleep_o == !conversion_start_n_i) else $error("m");
  chk_oe_start: assert property ($rose(busy_o) |-> ##[0:1] serial_result_oe_o) else $error("o");
endmodule

// ==== test/acs_sequencer_tb.sv ====
// Bench: both codings side by side, normal and sleep cycles.
// Assumes acs_host drives the pins; checker bound to each instance.
`timescale 1ns/100ps
module acs_sequencer_tb;
  reg         clk_sys_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [13:0] sar = 14'h0000;
  wire        st_n;
  wire        sclk;
  wire [1:0]  busy, hold, slp, so, oe, sd;
  integer     bad_count = 0;
  integer     total_checks = 0;
  integer     i;
  reg  [41:0] rows [0:4];
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : dut
      acs_sequencer #(.BIPOLAR(1 - g)) acs_sequencer_i
      (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .conversion_start_n_i(st_n),
       .serial_clk_i(sclk), .sar_code_i(sar), .busy_o(busy[g]), .track_hold_o(hold[g]),
       .sleep_o(slp[g]), .serial_result_out_o(so[g]), .serial_result_oe_o(oe[g]));
      assign sd[g] = oe[g] ? so[g] : 1'bz;
    end
  endgenerate
  acs_host acs_host_i (.clk_sys_i(clk_sys_i), .sdat_i(sd), .start_n_o(st_n), .sclk_o(sclk));
  initial
    forever #50 clk_sys_i = ~clk_sys_i;
  task chk(input [15:0] got, input [15:0] exp);
  begin
    total_checks = total_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  end
  endtask
  task end_of_test;
  begin
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  // Bounded wait; running out is a mismatch
  task wait_busy(input v, input integer lim);
    integer k;
  begin
    for (k = 0; busy[0] !== v && k < lim; k = k + 1)
      @(posedge clk_sys_i) #1;
    if (busy[0] !== v)
    begin
      chk(16'h0000, 16'h0001);
      end_of_test;
    end
  end
  endtask
  initial
  begin
    // Rows: core code, twos complement result, straight binary result
    rows[0] = {14'h2000, 14'h0000, 14'h2000};
    rows[1] = {14'h1FFF, 14'h3FFF, 14'h1FFF};
    rows[2] = {14'h0000, 14'h2000, 14'h0000};
    rows[3] = {14'h3FFF, 14'h1FFF, 14'h3FFF};
    rows[4] = {14'h0001, 14'h2001, 14'h0001};
    repeat (5) @(posedge clk_sys_i);
    #1 chk({8'h00, busy, hold, slp, oe}, 16'h0000);
    @(posedge clk_sys_i) rst_i <= 1'b0;
    for (i = 0; i < 5; i = i + 1)
    begin
      @(posedge clk_sys_i) sar <= rows[i][41:28];
      acs_host_i.start(1'b0);
      wait_busy(1'b1, 8);
      acs_host_i.start(1'b1);
      wait_busy(1'b0, 56);
      repeat (4) @(posedge clk_sys_i);
      acs_host_i.read;
      chk(acs_host_i.w[0], {2'b00, rows[i][27:14]});
      chk(acs_host_i.w[1], {2'b00, rows[i][13:0]});
      repeat (6) @(posedge clk_sys_i);
      #1 chk({14'h0000, oe}, 16'h0000);
    end
    acs_host_i.start(1'b0);
    wait_busy(1'b1, 8);
    wait_busy(1'b0, 56);
    chk({14'h0000, slp}, 16'h0003);
    repeat (20) @(posedge clk_sys_i);
    // Short wake pulse: the hold starts when the wake-up time runs out
    acs_host_i.start(1'b1);
    repeat (4) @(posedge clk_sys_i);
    acs_host_i.start(1'b0);
    wait_busy(1'b1, 60);
    chk({14'h0000, slp}, 16'h0000);
    // High before the end selects the high-sampling mode again
    acs_host_i.start(1'b1);
    wait_busy(1'b0, 56);
    chk({14'h0000, slp}, 16'h0000);
    end_of_test;
  end
endmodule
bind acs_sequencer acs_sequencer_sva acs_sequencer_sva_i (.clk_sys_i, .rst_i,
  .conversion_start_n_i, .busy_o, .track_hold_o, .sleep_o, .serial_result_oe_o);
